//--- logic/ddc_params.svh
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

// Frame and field layout of the serial command word.
`define DDC_WORD_BITS      16
`define DDC_CMD_MSB        15
`define DDC_CMD_LSB        12
`define DDC_CODE_MSB       11
`define DDC_CODE_LSB       0
`define DDC_BOTH_SEL_BIT   4
`define DDC_CHB_SEL_BIT    2
`define DDC_PWR_HI_BIT     1
`define DDC_PWR_LO_BIT     0
`define DDC_GUARD_BITS     15

// Reset values.
`define DDC_CODE_RESET     12'h000

// Timing: clock period, wake-up recovery and chip select high time.
`define DDC_CLK_PERIOD_NS  50
`define DDC_WAKE_TIME_NS   8000
`define DDC_WAKE_CYCLES    ((`DDC_WAKE_TIME_NS + `DDC_CLK_PERIOD_NS - 1) / `DDC_CLK_PERIOD_NS)
`define DDC_CS_HIGH_NS     80
`define DDC_CS_HIGH_CYCLES ((`DDC_CS_HIGH_NS + `DDC_CLK_PERIOD_NS - 1) / `DDC_CLK_PERIOD_NS)

`endif

//--- logic/ddc_pkg.sv
package ddc_pkg;

  // Command field encodings.
  typedef enum logic [3:0] {
    DDC_CMD_WR_OUT_A  = 4'h0,
    DDC_CMD_WR_OUT_B  = 4'h1,
    DDC_CMD_LD_STG_A  = 4'h4,
    DDC_CMD_LD_STG_B  = 4'h5,
    DDC_CMD_CP_A      = 4'h8,
    DDC_CMD_CP_B      = 4'h9,
    DDC_CMD_WR_OUT_AB = 4'hc,
    DDC_CMD_LD_STG_AB = 4'hd,
    DDC_CMD_CP_AB     = 4'he,
    DDC_CMD_PWR       = 4'hf
  } ddc_cmd_t;

  // Power state of one channel output.
  typedef enum logic [1:0] {
    DDC_PWR_ACTIVE   = 2'b00,
    DDC_PWR_FLOAT    = 2'b01,
    DDC_PWR_TERM_1K  = 2'b10,
    DDC_PWR_TERM_100K = 2'b11
  } ddc_pwr_t;

  // One received serial word.
  typedef struct packed {
    logic [3:0]  command_field;
    logic [11:0] code_field;
  } ddc_word_t;

  // Everything one channel shows to the analog side.
  typedef struct packed {
    logic [11:0] code;
    ddc_pwr_t    pwr;
    logic        buf_en;
    logic        settling;
  } ddc_chan_t;

endpackage

//--- logic/ddc_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for pin inputs.
module ddc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Asynchronous in, synchronous out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // ddc_sync

//--- logic/ddc_shift_rx.sv
`timescale 1ns/1ns
`include "ddc_params.svh"
// Frames the serial word: samples data on each falling serial clock edge while selected.
module ddc_shift_rx
  import ddc_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Synchronised link pins.
  input  wire logic        sclk_s,
  input  wire logic        din_s,
  input  wire logic        cs_n_s,
  // Completed word.
  output ddc_pkg::ddc_word_t word,
  output logic             word_valid
);
  import ddc_pkg::*;

  logic        sclk_d_reg;
  logic [15:0] shift_reg;
  logic [4:0]  count_reg;
  logic        sclk_fall;

  // Falling edge is found by comparison, so idle level does not matter.
  assign sclk_fall = sclk_d_reg & ~sclk_s;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sclk_d_reg <= 1'b0;
    else
      sclk_d_reg <= sclk_s;
  end

  // Shift and count; chip select high drops a partial word and rearms.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      shift_reg  <= 16'h0000;
      count_reg  <= 5'h00;
      word       <= '0;
      word_valid <= 1'b0;
    end
    else
    begin
      word_valid <= 1'b0;
      if (cs_n_s)
        count_reg <= 5'h00;
      else if (sclk_fall && count_reg < 5'(`DDC_WORD_BITS))
      begin
        shift_reg <= {shift_reg[14:0], din_s};
        count_reg <= count_reg + 5'h01;
        if (count_reg == 5'(`DDC_WORD_BITS - 1))
        begin
          word       <= ddc_word_t'({shift_reg[14:0], din_s});
          word_valid <= 1'b1;
        end
      end
    end
  end
endmodule // ddc_shift_rx

//--- logic/ddc_top.sv
`timescale 1ns/1ns
`include "ddc_params.svh"

// Overview of operation
// - After chip select falls, one data bit is captured each falling serial clock.
// - After sixteen bits the word acts at once, without waiting for chip select.
// - Host keeps chip select high 80ns between writes; each write starts falling.
// - Chip select rising in the first 15 clocks discards the word.
// - Serial clock may idle high or low.
// - Each channel has a staging register and an output register.
// - Both staging registers may load with outputs unchanged.
// - Transparent writes go straight to output register and update output.
// - Output changes only when its output register is written.
// - Code is unsigned 0 to 4095, output proportional to code over 4096.
// - Command 1111 controls power; bit four both, else bit two picks B.
// - Low two data bits: wake, float, 1k term, 100k term.
// - Power-down applies to one channel or both.
// - Powered-down channels keep staging and output registers.
// - Woken channel returns to its retained output code.
// - Wake-up recovery is 8us before outputs are trusted.
// - At power-up buffers are off and outputs terminated with 100k.
// - Word is MSB first: four command bits then twelve code bits.
// - Single-channel commands 000x, 010x, 100x with low bit choosing channel.
// - Dual commands 1100, 1101, 1110 act on both channels.
// - Reset clears registers, powers down; wait 8us after wake before writes.
module ddc_top
  import ddc_pkg::*;
#(
  parameter int WAKE_CYCLES = `DDC_WAKE_CYCLES
) (
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Serial link pins.
  input  wire logic          cs_n,
  input  wire logic          sclk,
  input  wire logic          din,
  // Channel state toward the analog side.
  output ddc_pkg::ddc_chan_t channel_a_output,
  output ddc_pkg::ddc_chan_t channel_b_output,
  // Debug view of the staging registers.
  output logic [11:0]        staging_a,
  output logic [11:0]        staging_b,
  // Pulses once for every completed word, even when its command is ignored.
  output logic               word_done
);
  import ddc_pkg::*;

  logic [2:0]  pins_s;
  logic        cs_n_s;
  logic        sclk_s;
  logic        din_s;
  ddc_word_t   word;
  logic        word_valid;
  ddc_cmd_t    cmd;
  logic [11:0] code;
  logic [11:0] stg_reg  [2];
  logic [11:0] out_reg  [2];
  ddc_pwr_t    pwr_reg  [2];
  logic [15:0] wake_cnt_reg [2];
  logic [1:0]  sel_ch;
  logic [1:0]  wr_out;
  logic [1:0]  ld_stg;
  logic [1:0]  cp_stg;
  logic [1:0]  pwr_wr;

  // Link pins come from another clock domain and are synchronised first.
  ddc_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({cs_n, sclk, din}),
    .sync_out (pins_s)
  );
  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s  = pins_s[0];

  // Receiver framing.
  ddc_shift_rx u_rx (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .sclk_s     (sclk_s),
    .din_s      (din_s),
    .cs_n_s     (cs_n_s),
    .word       (word),
    .word_valid (word_valid)
  );

  assign cmd  = ddc_cmd_t'(word.command_field);
  assign code = word.code_field; // Unsigned straight binary code.

  // Decode the completed word into per-channel strobes.
  always_comb
  begin
    wr_out = 2'b00;
    ld_stg = 2'b00;
    cp_stg = 2'b00;
    pwr_wr = 2'b00;
    sel_ch = word.command_field[0] ? 2'b10 : 2'b01;
    if (word_valid) // Acts without waiting for chip select.
    begin
      case (cmd)
        DDC_CMD_WR_OUT_A, DDC_CMD_WR_OUT_B: wr_out = sel_ch;
        DDC_CMD_LD_STG_A, DDC_CMD_LD_STG_B: ld_stg = sel_ch;
        DDC_CMD_CP_A, DDC_CMD_CP_B:         cp_stg = sel_ch;
        DDC_CMD_WR_OUT_AB:                  wr_out = 2'b11;
        DDC_CMD_LD_STG_AB:                  ld_stg = 2'b11;
        DDC_CMD_CP_AB:                      cp_stg = 2'b11;
        DDC_CMD_PWR:
        begin
          if (code[`DDC_BOTH_SEL_BIT])
            pwr_wr = 2'b11;
          else
            pwr_wr = code[`DDC_CHB_SEL_BIT] ? 2'b10 : 2'b01;
        end
        default:                            wr_out = 2'b00;
      endcase
    end
  end

  // Per-channel registers and power state.
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    // Staging register; untouched by power state.
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        stg_reg[i] <= `DDC_CODE_RESET;
      else if (ld_stg[i])
        stg_reg[i] <= code;
    end

    // Output register changes only on a direct write or a copy.
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        out_reg[i] <= `DDC_CODE_RESET;
      else if (wr_out[i])
        out_reg[i] <= code;
      else if (cp_stg[i])
        out_reg[i] <= stg_reg[i];
    end

    // Power state; reset leaves the output on its 100k termination.
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        pwr_reg[i] <= DDC_PWR_TERM_100K;
      else if (pwr_wr[i])
        pwr_reg[i] <= ddc_pwr_t'(code[`DDC_PWR_HI_BIT:`DDC_PWR_LO_BIT]);
    end

    // Recovery counter runs after a wake from power-down.
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        wake_cnt_reg[i] <= 16'h0000;
      else if (pwr_wr[i] && code[1:0] == 2'b00 && pwr_reg[i] != DDC_PWR_ACTIVE)
        wake_cnt_reg[i] <= 16'(WAKE_CYCLES);
      else if (pwr_wr[i])
        wake_cnt_reg[i] <= 16'h0000;
      else if (wake_cnt_reg[i] != 16'h0000)
        wake_cnt_reg[i] <= wake_cnt_reg[i] - 16'h0001;
    end
  end

  // Outputs toward the analog side; buffers enabled only when active.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      channel_a_output <= '{code: 12'h000, pwr: DDC_PWR_TERM_100K, buf_en: 1'b0,
                            settling: 1'b0};
      channel_b_output <= '{code: 12'h000, pwr: DDC_PWR_TERM_100K, buf_en: 1'b0,
                            settling: 1'b0};
      staging_a        <= 12'h000;
      staging_b        <= 12'h000;
      word_done        <= 1'b0;
    end
    else
    begin
      channel_a_output <= '{code: out_reg[0], pwr: pwr_reg[0],
                            buf_en: pwr_reg[0] == DDC_PWR_ACTIVE,
                            settling: wake_cnt_reg[0] != 16'h0000};
      channel_b_output <= '{code: out_reg[1], pwr: pwr_reg[1],
                            buf_en: pwr_reg[1] == DDC_PWR_ACTIVE,
                            settling: wake_cnt_reg[1] != 16'h0000};
      staging_a        <= stg_reg[0];
      staging_b        <= stg_reg[1];
      word_done        <= word_valid;
    end
  end

  // A staging load alone never moves the output register.
  property p_stage_only;
    @(posedge core_clk) disable iff (!rst_n)
    (ld_stg[0] && !wr_out[0] && !cp_stg[0]) |=> $stable(out_reg[0]);
  endproperty
  a_stage_only: assert property (p_stage_only) else $error("stage load moved output");

  property p_direct_write;
    @(posedge core_clk) disable iff (!rst_n)
    wr_out[1] |=> out_reg[1] == $past(code);
  endproperty
  a_direct_write: assert property (p_direct_write) else $error("direct write lost");

  property p_copy;
    @(posedge core_clk) disable iff (!rst_n)
    (cp_stg == 2'b11) |=> (out_reg[0] == $past(stg_reg[0])) && (out_reg[1] == $past(stg_reg[1]));
  endproperty
  a_copy: assert property (p_copy) else $error("dual copy failed");

  sequence s_cs_abort;
    !cs_n_s ##1 cs_n_s;
  endsequence
  property p_abort;
    @(posedge core_clk) disable iff (!rst_n)
    s_cs_abort |-> !word_valid [*2];
  endproperty
  a_abort: assert property (p_abort) else $error("word after chip select rise");

  property p_pwr_keep;
    @(posedge core_clk) disable iff (!rst_n)
    (pwr_reg[0] != DDC_PWR_ACTIVE && !wr_out[0] && !cp_stg[0]) |=> $stable(out_reg[0]);
  endproperty
  a_pwr_keep: assert property (p_pwr_keep) else $error("output changed in power-down");

  property p_pwr_both;
    @(posedge core_clk) disable iff (!rst_n)
    (word_valid && cmd == DDC_CMD_PWR && code[4]) |=> pwr_reg[0] == pwr_reg[1];
  endproperty
  a_pwr_both: assert property (p_pwr_both) else $error("joint power-down mismatch");

  property p_undef;
    @(posedge core_clk) disable iff (!rst_n)
    (word_valid && (cmd == 4'h2 || cmd == 4'h7 || cmd == 4'hb)) |=>
      $stable(out_reg[0]) && $stable(stg_reg[1]) && $stable(pwr_reg[0]);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined command acted");

  property p_wake;
    @(posedge core_clk) disable iff (!rst_n)
    (pwr_wr[0] && code[1:0] == 2'b00 && pwr_reg[0] != DDC_PWR_ACTIVE) |=>
      wake_cnt_reg[0] == 16'(WAKE_CYCLES) ##1 wake_cnt_reg[0] == 16'(WAKE_CYCLES - 1);
  endproperty
  a_wake: assert property (p_wake) else $error("wake recovery count wrong");

  property p_reset_state;
    @(posedge core_clk)
    !rst_n |=> pwr_reg[1] == DDC_PWR_TERM_100K && out_reg[1] == 12'h000;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  // Every completed word gives one pulse, even when its command is ignored.
  property p_word_done;
    @(posedge core_clk) disable iff (!rst_n)
    word_valid |=> word_done;
  endproperty
  a_word_done: assert property (p_word_done) else $error("word pulse missing");

  // A powered-down output must never have its buffer driving the pin.
  property p_buf_off;
    @(posedge core_clk) disable iff (!rst_n)
    (pwr_reg[1] != DDC_PWR_ACTIVE) |=> !channel_b_output.buf_en;
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffer on in power-down");

  // Loading B's staging register takes the code and leaves its output register alone.
  property p_stage_b;
    @(posedge core_clk) disable iff (!rst_n)
    (ld_stg[1] && !wr_out[1] && !cp_stg[1]) |=>
      $stable(out_reg[1]) && stg_reg[1] == $past(code);
  endproperty
  a_stage_b: assert property (p_stage_b) else $error("staging load moved output");

  // A power command aimed at A alone never changes B's power state.
  property p_pwr_one;
    @(posedge core_clk) disable iff (!rst_n)
    (pwr_wr == 2'b01) |=> $stable(pwr_reg[1]);
  endproperty
  a_pwr_one: assert property (p_pwr_one) else $error("other channel powered");

  // The remaining undefined codes leave the other registers untouched as well.
  property p_undef_rest;
    @(posedge core_clk) disable iff (!rst_n)
    (word_valid && (cmd == 4'h3 || cmd == 4'h6 || cmd == 4'ha)) |=>
      $stable(out_reg[1]) && $stable(stg_reg[0]) && $stable(pwr_reg[1]);
  endproperty
  a_undef_rest: assert property (p_undef_rest) else $error("undefined code acted");

  // Power-down may be applied at once, so it cancels a running recovery.
  property p_wake_cancel;
    @(posedge core_clk) disable iff (!rst_n)
    (pwr_wr[1] && code[1:0] != 2'b00) |=> wake_cnt_reg[1] == 16'h0000;
  endproperty
  a_wake_cancel: assert property (p_wake_cancel) else $error("recovery kept");

  // Recovery ends: the last count is followed by zero and the flag drops.
  property p_wake_end;
    @(posedge core_clk) disable iff (!rst_n)
    (wake_cnt_reg[1] == 16'h0001 && !pwr_wr[1]) |=>
      wake_cnt_reg[1] == 16'h0000 ##1 !channel_b_output.settling;
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("recovery did not end");

  // A single-channel copy moves A's staged code into its output register.
  property p_copy_a;
    @(posedge core_clk) disable iff (!rst_n)
    (cp_stg[0] && !wr_out[0]) |=> out_reg[0] == $past(stg_reg[0]);
  endproperty
  a_copy_a: assert property (p_copy_a) else $error("copy to A failed");

endmodule // ddc_top

//--- tb/ddc_host_model.sv
`timescale 1ns/1ns
// Serial master model; the link clock stands still between frames.
module ddc_host_model (
  // Clock.
  input  wire logic core_clk,
  // Link pins.
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // Shifts the top nbits of w, MSB first, each half period four cycles (200 ns).
  // A short frame is cut off by raising chip select, which the device must discard.
  task automatic send(input logic [15:0] w, input int nbits, input bit idle_hi, input bit keep);
    int i;
    if (cs_n == 1'b0)
    begin
      @(posedge core_clk) cs_n <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
    @(posedge core_clk) sclk <= idle_hi;
    repeat (2) @(posedge core_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (i = 15; i > 15 - nbits; i--)
    begin
      sclk <= 1'b1;
      din  <= w[i];
      repeat (4) @(posedge core_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    // The released data line shows the inverse so a stale bit is never mistaken for data.
    sclk <= idle_hi;
    din  <= ~din;
    repeat (4) @(posedge core_clk);
    cs_n <= (keep && nbits == 16) ? 1'b0 : 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // ddc_host_model

//--- tb/ddc_top_test.sv
`timescale 1ns/1ns
// Self-checking bench: random and corner frames against a reference register model.
module ddc_top_test;
  import ddc_pkg::*;
  localparam int WAKE = 40;
  logic        core_clk;
  logic        rst_n;
  logic        cs_n;
  logic        sclk;
  logic        din;
  ddc_chan_t   ch[2];
  logic [11:0] stg[2];
  logic        word_done;
  int          errors = 0;
  int          n_compared = 0;
  int          n_done = 0;
  int          e_done = 0;
  logic [11:0] e_code[2];
  logic [11:0] e_stg[2];
  logic [1:0]  e_pwr[2];

  ddc_top #(.WAKE_CYCLES(WAKE)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
    .channel_a_output(ch[0]), .channel_b_output(ch[1]),
    .staging_a(stg[0]), .staging_b(stg[1]), .word_done(word_done));

  ddc_host_model host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .din(din));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Counts word pulses so every complete frame can be matched to exactly one pulse.
  always @(posedge core_clk)
    if (word_done === 1'b1)
      n_done++;

  // Expected register state after one complete word; copies read staging first.
  function automatic void model(logic [15:0] w);
    int k;
    e_done++;
    for (k = 0; k < 2; k++)
    begin
      if (w[15:12] == {3'b100, k[0]} || w[15:12] == 4'he)
        e_code[k] = e_stg[k];
      if (w[15:12] == {3'b000, k[0]} || w[15:12] == 4'hc)
        e_code[k] = w[11:0];
      if (w[15:12] == {3'b010, k[0]} || w[15:12] == 4'hd)
        e_stg[k] = w[11:0];
      if (w[15:12] == 4'hf && (w[4] || w[2] == k[0]))
        e_pwr[k] = w[1:0];
    end
  endfunction

  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compares both channels and the word count away from the clock edge.
  task automatic chk(string what);
    int k;
    @(negedge core_clk);
    for (k = 0; k < 2; k++)
    begin
      n_compared++;
      if (ch[k].code !== e_code[k] || stg[k] !== e_stg[k] || ch[k].pwr !== e_pwr[k]
          || ch[k].buf_en !== (e_pwr[k] == 2'b00))
      begin
        errors++;
        $display("ERROR %0t: %s ch %0d code %h stg %h pwr %b", $time, what, k,
                 ch[k].code, stg[k], ch[k].pwr);
      end
    end
    n_compared++;
    if (n_done != e_done)
    begin
      errors++;
      $display("ERROR %0t: %s word count %0d expected %0d", $time, what, n_done, e_done);
    end
  endtask

  task automatic xfer(logic [15:0] w, string what);
    host.send(w, 16, 1'($urandom_range(1)), 1'($urandom_range(1)));
    model(w);
    chk(what);
  endtask

  // Recovery flag must be up after a wake and drop within the recovery time.
  task automatic settle();
    int t;
    n_compared++;
    for (t = 0; t <= WAKE && (ch[0].settling === 1'b1 || ch[1].settling === 1'b1); t++)
      @(negedge core_clk);
    if (t < WAKE / 2 || t > WAKE)
    begin
      errors++;
      $display("ERROR %0t: recovery lasted %0d cycles", $time, t);
      end_of_test();
    end
  endtask

  initial
  begin
    #(50 * 90000);
    errors++;
    $display("ERROR %0t: run timed out", $time);
    end_of_test();
  end

  initial
  begin
    int i;
    logic [15:0] w;
    rst_n = 1'b0;
    e_code = '{12'h000, 12'h000};
    e_stg = '{12'h000, 12'h000};
    e_pwr = '{2'b11, 2'b11};
    void'($urandom(32'h0b60));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    chk("reset");
    xfer(16'hf010, "wake");
    settle();
    // Every non-power command once, full-scale code first.
    for (i = 0; i < 15; i++)
    begin
      w = {i[3:0], i == 0 ? 12'hfff : 12'($urandom)};
      xfer(w, "cmd");
    end
    for (i = 0; i < 40; i++)
    begin
      w = 16'($urandom);
      if (w[15:12] == 4'hf)
        w[15:12] = 4'hd;
      xfer(w, "rand");
    end
    host.send(16'h0abc, 15, 1'b0, 1'b0);
    chk("short");
    // Each power-down state on A, B and both, each followed by a wake.
    for (i = 0; i < 9; i++)
    begin
      w = {4'hf, 7'h00, 1'(i / 3 == 2), 1'b0, 1'(i / 3 == 1), 2'(i % 3 + 1)};
      xfer(w, "down");
      w[1:0] = 2'b00;
      xfer(w, "wake");
      settle();
    end
    end_of_test();
  end
endmodule // ddc_top_test
